/* File: shared/sct_pkg.sv */
// Register map, field layout and decoded configuration types for the sense channel setup.
package sct_pkg;
   // Register offsets.
   localparam logic [7:0] CH0_MODE_CONFIG_OFS = 8'h40;
   localparam logic [7:0] CH1_MODE_CONFIG_OFS = 8'h41;
   localparam logic [7:0] SHARED_CHARGE_TUNING_OFS = 8'h42;
   localparam logic [7:0] CH0_TUNING_OFS = 8'h43;
   localparam logic [7:0] CH1_TUNING_OFS = 8'h44;
   localparam logic [7:0] SHARED_FILTER_OFS = 8'h45;
   localparam logic [7:0] CH0_COMP_LOW_OFS = 8'h46;
   localparam logic [7:0] CH1_COMP_LOW_OFS = 8'h47;
   localparam logic [7:0] CH0_MULT_OFS = 8'h48;
   localparam logic [7:0] CH1_MULT_OFS = 8'h49;
   localparam int NUM_REGS = 10;
   localparam int NUM_CHAN = 2;

   // Register indices, counted from the first offset.
   localparam int IDX_MODE = 0;
   localparam int IDX_CHARGE = 2;
   localparam int IDX_TUNING = 3;
   localparam int IDX_FILTER = 5;
   localparam int IDX_COMP = 6;
   localparam int IDX_MULT = 8;

   // Reset values.
   localparam logic [7:0] MODE_CONFIG_RST = 8'h00;
   localparam logic [7:0] CHARGE_TUNING_RST = 8'h5B;
   localparam logic [7:0] TUNING_RST = 8'h50;
   localparam logic [7:0] FILTER_RST = 8'h00;
   localparam logic [7:0] COMP_RST = 8'h00;
   localparam logic [7:0] MULT_RST = 8'h00;

   // Field positions.
   localparam int MODE_MSB = 7;
   localparam int MODE_LSB = 4;
   localparam int TX_MSB = 3;
   localparam int TX_LSB = 2;
   localparam int RX_MSB = 1;
   localparam int RX_LSB = 0;
   localparam int CAP_SIZE_BIT = 6;
   localparam int CHARGE_MSB = 5;
   localparam int CHARGE_LSB = 4;
   localparam int BIAS_MSB = 3;
   localparam int BIAS_LSB = 2;
   localparam int TUNE_MSB = 1;
   localparam int TUNE_LSB = 0;
   localparam int BASE_MSB = 7;
   localparam int BASE_LSB = 6;
   localparam int TARGET_MSB = 5;
   localparam int TARGET_LSB = 0;
   localparam int CS_DIV_BIT = 6;
   localparam int TWO_SIDED_BIT = 5;
   localparam int ACF_DIS_BIT = 4;
   localparam int LTA_BETA_MSB = 3;
   localparam int LTA_BETA_LSB = 2;
   localparam int ACF_BETA_MSB = 1;
   localparam int ACF_BETA_LSB = 0;
   localparam int COMP_HI_MSB = 7;
   localparam int COMP_HI_LSB = 6;
   localparam int COARSE_MSB = 5;
   localparam int COARSE_LSB = 4;
   localparam int FINE_MSB = 3;
   localparam int FINE_LSB = 0;

   // Encodings and values.
   localparam logic [3:0] MODE_SELF_CAP = 4'h0;
   localparam logic [3:0] MODE_MUTUAL_IND = 4'h9;
   localparam logic [7:0] BASE_VAL_0 = 8'h4B;
   localparam logic [7:0] BASE_VAL_1 = 8'h64;
   localparam logic [7:0] BASE_VAL_2 = 8'h96;
   localparam logic [7:0] BASE_VAL_3 = 8'hC8;
   localparam logic [4:0] TARGET_SCALE_ZEROS = 5'h00;
   localparam logic [4:0] CHARGE_DIV_MIN = 5'h02;

   typedef enum logic [1:0] {TUNE_OFF, TUNE_PARTIAL, TUNE_SEMI_PARTIAL, TUNE_FULL} sct_tune_t;

   typedef struct packed {
      logic self_cap;
      logic inductive;
      logic [1:0] tx_en;
      logic [1:0] rx_en;
      logic [7:0] base_value;
      logic [10:0] target_value;
      logic [9:0] compensation;
      logic [1:0] coarse_mult;
      logic [3:0] fine_mult;
   } sct_chan_cfg_t;

   typedef struct packed {
      logic cap_60pf;
      logic [4:0] charge_div;
      logic [1:0] bias_sel;
      sct_tune_t tune_mode;
      logic cs_div_en;
      logic two_sided;
      logic ac_filter_en;
      logic [1:0] lta_beta;
      logic [1:0] acf_beta;
   } sct_shared_cfg_t;
endpackage : sct_pkg

/* File: hw/sct_config_regs.sv */
// Sense channel configuration register bank behind an I2C slave, with applied settings and event flags.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Mode field 0000 selects self capacitive, 1001 selects mutual inductive sensing.
// - Transmit select 00 disables both transmit electrodes.
// - Receive select 00 none, 01 receiver 0, 10 receiver 1, 11 both.
// - Shared bit 6 picks sensing capacitor of 15 pF or 60 pF.
// - Charge frequency code 00 to 11 divides sampling by 2, 4, 8, 16.
// - Projected bias code picks one of four rising bias settings.
// - Tuning mode: off, partial, semi-partial, full for codes 00 to 11.
// - Tuning base bits 7:6 give 75, 100, 150 or 200.
// - Tuning target equals the 6-bit field times 32.
// - Filter bit 6 enables the sampling capacitor divider.
// - Filter bit 5 enables two-sided detection.
// - Filter bit 4 set disables the AC filter.
// - Compensation is 10 bits: upper two from multiplier register, lower eight.
// - Multiplier register holds coarse select in bits 5:4, fine in 3:0.
// - Flag an event when average minus count exceeds the channel threshold.
module sct_config_regs #(
   parameter logic [6:0] I2C_ADDR = 7'h44, // Arbitrary slave address.
   parameter int DATA_W = 16
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // I2C pins, taken as synchronous
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   // Sensing engine
   input wire logic meas_start_i,
   input wire logic sample_valid_i,
   input wire logic [sct_pkg::NUM_CHAN-1:0][DATA_W-1:0] lta_i,
   input wire logic [sct_pkg::NUM_CHAN-1:0][DATA_W-1:0] count_i,
   input wire logic [sct_pkg::NUM_CHAN-1:0][7:0] threshold_i,
   output sct_pkg::sct_chan_cfg_t [sct_pkg::NUM_CHAN-1:0] chan_cfg_o,
   output sct_pkg::sct_shared_cfg_t shared_cfg_o,
   output logic [sct_pkg::NUM_CHAN-1:0] event_o
);
   localparam int NUM_CH = sct_pkg::NUM_CHAN;

   if (DATA_W < 8) begin : g_bad_width
      $error("DATA_W must be at least 8");
   end

   typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD,
      ST_RD_ACK} sct_state_t;

   function automatic logic reg_hit(input logic [7:0] ptr);
      reg_hit = (ptr >= sct_pkg::CH0_MODE_CONFIG_OFS) && (ptr <= sct_pkg::CH1_MULT_OFS);
   endfunction : reg_hit

   function automatic logic [3:0] reg_idx(input logic [7:0] ptr);
      logic [7:0] diff;
      diff = ptr - sct_pkg::CH0_MODE_CONFIG_OFS;
      reg_idx = diff[3:0];
   endfunction : reg_idx

   sct_state_t state_q, state_d;
   logic scl_q, sda_q;
   logic [7:0] shift_q, shift_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic nack_q, nack_d;
   logic oe_n_q, oe_n_d;
   logic [7:0] regs_q [sct_pkg::NUM_REGS];
   logic [7:0] regs_d [sct_pkg::NUM_REGS];
   logic [7:0] rd_data;
   logic start_c, stop_c, rise_c, fall_c;

   assign start_c = scl_i && scl_q && sda_q && !sda_i;
   assign stop_c = scl_i && scl_q && !sda_q && sda_i;
   assign rise_c = scl_i && !scl_q;
   assign fall_c = !scl_i && scl_q;
   assign rd_data = reg_hit(ptr_q) ? regs_q[reg_idx(ptr_q)] : 8'h00;

   // Bus protocol and register writes.
   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      cnt_d = cnt_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      nack_d = nack_q;
      oe_n_d = oe_n_q;
      regs_d = regs_q;
      if (start_c) begin
         state_d = ST_ADDR;
         cnt_d = 4'h0;
         oe_n_d = 1'b1;
      end else if (stop_c) begin
         state_d = ST_IDLE;
         oe_n_d = 1'b1;
      end else begin
         case (state_q)
            ST_ADDR, ST_PTR, ST_WR: begin
               if (rise_c && cnt_q < 4'h8) begin
                  shift_d = {shift_q[6:0], sda_i};
                  cnt_d = cnt_q + 4'h1;
               end else if (fall_c && cnt_q == 4'h8) begin
                  oe_n_d = 1'b0;
                  if (state_q == ST_ADDR) begin
                     if (shift_q[7:1] == I2C_ADDR) begin
                        rw_d = shift_q[0];
                        state_d = ST_ADDR_ACK;
                     end else begin
                        oe_n_d = 1'b1;
                        state_d = ST_IDLE;
                     end
                  end else if (state_q == ST_PTR) begin
                     ptr_d = shift_q;
                     state_d = ST_PTR_ACK;
                  end else begin
                     // Unmapped writes are acknowledged and dropped.
                     if (reg_hit(ptr_q)) begin
                        regs_d[reg_idx(ptr_q)] = shift_q;
                     end
                     ptr_d = ptr_q + 8'h01;
                     state_d = ST_WR_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (fall_c) begin
                  cnt_d = 4'h0;
                  if (rw_q) begin
                     shift_d = rd_data;
                     oe_n_d = rd_data[7];
                     ptr_d = ptr_q + 8'h01;
                     state_d = ST_RD;
                  end else begin
                     oe_n_d = 1'b1;
                     state_d = ST_PTR;
                  end
               end
            end
            ST_PTR_ACK, ST_WR_ACK: begin
               if (fall_c) begin
                  oe_n_d = 1'b1;
                  cnt_d = 4'h0;
                  state_d = ST_WR;
               end
            end
            ST_RD: begin
               if (rise_c) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (fall_c) begin
                  if (cnt_q == 4'h8) begin
                     oe_n_d = 1'b1;
                     state_d = ST_RD_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_n_d = shift_q[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (rise_c) begin
                  nack_d = sda_i;
               end else if (fall_c) begin
                  if (nack_q) begin
                     state_d = ST_IDLE;
                  end else begin
                     cnt_d = 4'h0;
                     shift_d = rd_data;
                     oe_n_d = rd_data[7];
                     ptr_d = ptr_q + 8'h01;
                     state_d = ST_RD;
                  end
               end
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         oe_n_q <= 1'b1;
         for (int c = 0; c < NUM_CH; c++) begin
            regs_q[sct_pkg::IDX_MODE + c] <= sct_pkg::MODE_CONFIG_RST;
            regs_q[sct_pkg::IDX_TUNING + c] <= sct_pkg::TUNING_RST;
            regs_q[sct_pkg::IDX_COMP + c] <= sct_pkg::COMP_RST;
            regs_q[sct_pkg::IDX_MULT + c] <= sct_pkg::MULT_RST;
         end
         regs_q[sct_pkg::IDX_CHARGE] <= sct_pkg::CHARGE_TUNING_RST;
         regs_q[sct_pkg::IDX_FILTER] <= sct_pkg::FILTER_RST;
      end else begin
         state_q <= state_d;
         scl_q <= scl_i;
         sda_q <= sda_i;
         shift_q <= shift_d;
         cnt_q <= cnt_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         oe_n_q <= oe_n_d;
         regs_q <= regs_d;
      end
   end

   assign sda_oe_n_o = oe_n_q;
   assign sda_o = 1'b0;

   // Decoded settings, latched only at a measurement start so a running conversion keeps its setup.
   sct_pkg::sct_chan_cfg_t [NUM_CH-1:0] cfg_q, cfg_d;
   sct_pkg::sct_shared_cfg_t shr_q, shr_d;
   logic [NUM_CH-1:0] event_q, event_d;
   logic [7:0] base_tab [4];

   assign base_tab[0] = sct_pkg::BASE_VAL_0;
   assign base_tab[1] = sct_pkg::BASE_VAL_1;
   assign base_tab[2] = sct_pkg::BASE_VAL_2;
   assign base_tab[3] = sct_pkg::BASE_VAL_3;

   always_comb begin
      logic [7:0] m, t, p, k, f, s;
      logic [DATA_W-1:0] diff;
      cfg_d = cfg_q;
      shr_d = shr_q;
      event_d = event_q;
      s = regs_q[sct_pkg::IDX_CHARGE];
      f = regs_q[sct_pkg::IDX_FILTER];
      m = 8'h00;
      t = 8'h00;
      p = 8'h00;
      k = 8'h00;
      diff = '0;
      if (meas_start_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            m = regs_q[sct_pkg::IDX_MODE + c];
            t = regs_q[sct_pkg::IDX_TUNING + c];
            p = regs_q[sct_pkg::IDX_COMP + c];
            k = regs_q[sct_pkg::IDX_MULT + c];
            cfg_d[c].self_cap = m[sct_pkg::MODE_MSB:sct_pkg::MODE_LSB] == sct_pkg::MODE_SELF_CAP;
            cfg_d[c].inductive = m[sct_pkg::MODE_MSB:sct_pkg::MODE_LSB] == sct_pkg::MODE_MUTUAL_IND;
            cfg_d[c].tx_en = m[sct_pkg::TX_MSB:sct_pkg::TX_LSB];
            cfg_d[c].rx_en = m[sct_pkg::RX_MSB:sct_pkg::RX_LSB];
            cfg_d[c].base_value = base_tab[t[sct_pkg::BASE_MSB:sct_pkg::BASE_LSB]];
            cfg_d[c].target_value = {t[sct_pkg::TARGET_MSB:sct_pkg::TARGET_LSB], sct_pkg::TARGET_SCALE_ZEROS};
            cfg_d[c].compensation = {k[sct_pkg::COMP_HI_MSB:sct_pkg::COMP_HI_LSB], p};
            cfg_d[c].coarse_mult = k[sct_pkg::COARSE_MSB:sct_pkg::COARSE_LSB];
            cfg_d[c].fine_mult = k[sct_pkg::FINE_MSB:sct_pkg::FINE_LSB];
         end
         shr_d.cap_60pf = s[sct_pkg::CAP_SIZE_BIT];
         shr_d.charge_div = sct_pkg::CHARGE_DIV_MIN << s[sct_pkg::CHARGE_MSB:sct_pkg::CHARGE_LSB];
         shr_d.bias_sel = s[sct_pkg::BIAS_MSB:sct_pkg::BIAS_LSB];
         shr_d.tune_mode = sct_pkg::sct_tune_t'(s[sct_pkg::TUNE_MSB:sct_pkg::TUNE_LSB]);
         shr_d.cs_div_en = f[sct_pkg::CS_DIV_BIT];
         shr_d.two_sided = f[sct_pkg::TWO_SIDED_BIT];
         shr_d.ac_filter_en = !f[sct_pkg::ACF_DIS_BIT];
         shr_d.lta_beta = f[sct_pkg::LTA_BETA_MSB:sct_pkg::LTA_BETA_LSB];
         shr_d.acf_beta = f[sct_pkg::ACF_BETA_MSB:sct_pkg::ACF_BETA_LSB];
      end
      if (sample_valid_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            // A count above the average only counts when two-sided detection is on.
            if (lta_i[c] > count_i[c]) begin
               diff = lta_i[c] - count_i[c];
            end else if (shr_q.two_sided) begin
               diff = count_i[c] - lta_i[c];
            end else begin
               diff = '0;
            end
            event_d[c] = diff > DATA_W'(threshold_i[c]);
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_q <= '0;
         shr_q <= '0;
         event_q <= '0;
      end else begin
         cfg_q <= cfg_d;
         shr_q <= shr_d;
         event_q <= event_d;
      end
   end

   assign chan_cfg_o = cfg_q;
   assign shared_cfg_o = shr_q;
   assign event_o = event_q;

   a_mode_inductive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i && regs_q[sct_pkg::IDX_MODE + 1][7:4] == 4'h9 |=> cfg_q[1].inductive && !cfg_q[1].self_cap)
      else $error("inductive mode not applied");
   a_rx_decode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i |=> cfg_q[1].rx_en == $past(regs_q[sct_pkg::IDX_MODE + 1][1:0]))
      else $error("receive select mismatch");
   a_charge_div: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i && regs_q[sct_pkg::IDX_CHARGE][5:4] == 2'h3 |=> shr_q.charge_div == 5'h10)
      else $error("charge divide wrong");
   a_base_value: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i && regs_q[sct_pkg::IDX_TUNING][7:6] == 2'h2 |=> cfg_q[0].base_value == 8'h96)
      else $error("tuning base wrong");
   a_target_scale: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i |=> cfg_q[0].target_value == 11'($past(regs_q[sct_pkg::IDX_TUNING][5:0]) * 32))
      else $error("tuning target wrong");
   a_acf_disable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i && regs_q[sct_pkg::IDX_FILTER][4] |=> !shr_q.ac_filter_en)
      else $error("ac filter not disabled");
   a_comp_join: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      meas_start_i |=> cfg_q[1].compensation[9:8] == $past(regs_q[sct_pkg::IDX_MULT + 1][7:6])
      && cfg_q[1].compensation[7:0] == $past(regs_q[sct_pkg::IDX_COMP + 1]))
      else $error("compensation join wrong");
   a_cfg_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !meas_start_i |=> $stable(cfg_q) && $stable(shr_q))
      else $error("settings changed mid measurement");
   a_event_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sample_valid_i && lta_i[0] > count_i[0] && (lta_i[0] - count_i[0]) > DATA_W'(threshold_i[0])
      |=> event_o[0])
      else $error("event not flagged");
endmodule : sct_config_regs

`default_nettype wire

/* File: tb/sct_i2c_host.sv */
// Behavioural I2C host that drives the bus clock and the open-drain data line of the register bank.
`timescale 1ns/1ps
`default_nettype none

module sct_i2c_host (
   // Clock
   input wire logic ref_clk_i,
   // Bus, high on sda_o means released
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask : wait_clk

   // Phases of two reference cycles are twice the shortest the block accepts, so this host keeps a cycle of margin.
   task automatic bit_cycle(input logic b, output logic s);
      sda_o <= b;
      wait_clk(2);
      scl_o <= 1'b1;
      wait_clk(2);
      s = sda_i;
      wait_clk(2);
      scl_o <= 1'b0;
      wait_clk(2);
   endtask : bit_cycle

   // Serves as a first start from idle and as a repeated start with the clock low.
   task automatic start();
      sda_o <= 1'b1;
      wait_clk(2);
      scl_o <= 1'b1;
      wait_clk(4);
      sda_o <= 1'b0;
      wait_clk(4);
      scl_o <= 1'b0;
      wait_clk(2);
   endtask : start

   task automatic stop();
      sda_o <= 1'b0;
      wait_clk(2);
      scl_o <= 1'b1;
      wait_clk(4);
      sda_o <= 1'b1;
      wait_clk(4);
   endtask : stop

   // Sends d_out and ack_out, and returns what the wire showed; release a line by sending ones.
   task automatic byte_xfer(input logic [7:0] d_out, input logic ack_out, output logic [7:0] d_in,
                            output logic ack_in);
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(d_out[i], d_in[i]);
      end
      bit_cycle(ack_out, ack_in);
   endtask : byte_xfer
endmodule : sct_i2c_host

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking testbench for the sense channel configuration register bank.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [6:0] ADDR = 7'h44;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic scl;
   logic host_sda;
   logic dut_sda;
   logic dut_oe_n;
   logic meas_start = 1'b0;
   logic sample_valid = 1'b0;
   logic [1:0][15:0] long_term_average = '0;
   logic [1:0][15:0] count = '0;
   logic [1:0][7:0] thr = {8'h64, 8'h64};
   sct_pkg::sct_chan_cfg_t [1:0] chan_cfg;
   sct_pkg::sct_shared_cfg_t shared_cfg;
   logic [1:0] event_flags;
   int bad_count = 0;
   int n_compared = 0;
   logic [7:0] shadow [10] = '{8'h00, 8'h00, 8'h5B, 8'h50, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] base_tab [4] = '{8'h4B, 8'h64, 8'h96, 8'hC8};
   sct_pkg::sct_chan_cfg_t exp_ch [2] = '{'0, '0};
   sct_pkg::sct_shared_cfg_t exp_sh = '0;
   // The data line has a pull-up, so a released line reads high.
   wire logic sda_line = host_sda & (dut_oe_n ? 1'b1 : dut_sda);

   always #20 ref_clk = ~ref_clk;

   sct_i2c_host host (.ref_clk_i(ref_clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));

   sct_config_regs #(.I2C_ADDR(ADDR), .DATA_W(16)) dut (
      .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_line), .sda_o(dut_sda),
      .sda_oe_n_o(dut_oe_n), .meas_start_i(meas_start), .sample_valid_i(sample_valid), .lta_i(long_term_average),
      .count_i(count), .threshold_i(thr), .chan_cfg_o(chan_cfg), .shared_cfg_o(shared_cfg),
      .event_o(event_flags));

   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
      logic [7:0] junk;
      logic [2:0] ack;
      @(posedge ref_clk);
      host.start();
      host.byte_xfer({ADDR, 1'b0}, 1'b1, junk, ack[2]);
      host.byte_xfer(ptr, 1'b1, junk, ack[1]);
      host.byte_xfer(d, 1'b1, junk, ack[0]);
      host.stop();
      check(64'(ack), 64'h0);
      if (ptr >= 8'h40 && ptr <= 8'h49) begin
         shadow[ptr - 8'h40] = d;
      end
   endtask : wr

   task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
      logic [7:0] junk;
      logic [2:0] ack;
      logic nack;
      @(posedge ref_clk);
      host.start();
      host.byte_xfer({ADDR, 1'b0}, 1'b1, junk, ack[2]);
      host.byte_xfer(ptr, 1'b1, junk, ack[1]);
      host.start();
      host.byte_xfer({ADDR, 1'b1}, 1'b1, junk, ack[0]);
      host.byte_xfer(8'hFF, 1'b1, d, nack);
      host.stop();
      check(64'(ack), 64'h0);
   endtask : rd

   function automatic sct_pkg::sct_chan_cfg_t chan_exp(input int c);
      sct_pkg::sct_chan_cfg_t e;
      logic [7:0] m;
      logic [7:0] t;
      logic [7:0] mu;
      m = shadow[c];
      t = shadow[3 + c];
      mu = shadow[8 + c];
      e.self_cap = (m[7:4] == 4'h0);
      e.inductive = (m[7:4] == 4'h9);
      e.tx_en = m[3:2];
      e.rx_en = m[1:0];
      e.base_value = base_tab[t[7:6]];
      e.target_value = {t[5:0], 5'h00};
      e.compensation = {mu[7:6], shadow[6 + c]};
      e.coarse_mult = mu[5:4];
      e.fine_mult = mu[3:0];
      return e;
   endfunction : chan_exp

   function automatic sct_pkg::sct_shared_cfg_t shared_exp();
      sct_pkg::sct_shared_cfg_t e;
      e.cap_60pf = shadow[2][6];
      e.charge_div = 5'h02 << shadow[2][5:4];
      e.bias_sel = shadow[2][3:2];
      e.tune_mode = sct_pkg::sct_tune_t'(shadow[2][1:0]);
      e.cs_div_en = shadow[5][6];
      e.two_sided = shadow[5][5];
      e.ac_filter_en = ~shadow[5][4];
      e.lta_beta = shadow[5][3:2];
      e.acf_beta = shadow[5][1:0];
      return e;
   endfunction : shared_exp

   // Outputs must hold the last applied settings until the measurement start pulse.
   task automatic apply();
      @(posedge ref_clk);
      check(64'(chan_cfg[0]), 64'(exp_ch[0]));
      check(64'(chan_cfg[1]), 64'(exp_ch[1]));
      check(64'(shared_cfg), 64'(exp_sh));
      meas_start <= 1'b1;
      @(posedge ref_clk);
      meas_start <= 1'b0;
      @(posedge ref_clk);
      #1;
      exp_ch[0] = chan_exp(0);
      exp_ch[1] = chan_exp(1);
      exp_sh = shared_exp();
      check(64'(chan_cfg[0]), 64'(exp_ch[0]));
      check(64'(chan_cfg[1]), 64'(exp_ch[1]));
      check(64'(shared_cfg), 64'(exp_sh));
   endtask : apply

   task automatic ev(input logic [15:0] l0, input logic [15:0] c0, input logic [15:0] l1,
                     input logic [15:0] c1, input logic [1:0] want);
      @(posedge ref_clk);
      long_term_average <= {l1, l0};
      count <= {c1, c0};
      sample_valid <= 1'b1;
      @(posedge ref_clk);
      sample_valid <= 1'b0;
      @(posedge ref_clk);
      #1;
      check(64'(event_flags), 64'(want));
   endtask : ev

   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] junk;
      logic ack;
      check(64'(event_flags), 64'h0);
      for (int i = 0; i < 10; i++) begin
         rd(8'h40 + 8'(i), d);
         check(64'(d), 64'(shadow[i]));
      end
      @(posedge ref_clk);
      host.start();
      host.byte_xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, junk, ack);
      host.stop();
      check(64'(ack), 64'h1);
      $display("Test reset done");
   endtask : t_reset

   task automatic t_mode();
      for (int i = 0; i < 4; i++) begin
         wr(8'h40, {4'h0, 2'(3 - i), 2'(i)});
         wr(8'h41, {4'h9, 2'b00, ~2'(i)});
         apply();
      end
      $display("Test mode done");
   endtask : t_mode

   task automatic t_shared();
      for (int i = 0; i < 4; i++) begin
         wr(8'h42, {1'b0, ~i[0], 2'(i), 2'(3 - i), 2'(i)});
         wr(8'h43, {2'(i), 6'h3F});
         wr(8'h44, {~2'(i), 6'(i)});
         apply();
      end
      $display("Test shared done");
   endtask : t_shared

   task automatic t_filter();
      logic [7:0] fv [4] = '{8'h7F, 8'h20, 8'h10, 8'h00};
      for (int i = 0; i < 4; i++) begin
         wr(8'h45, fv[i]);
         apply();
         ev(16'h012D, 16'h00C8, 16'h00C8, 16'h012D, {fv[i][5], 1'b1});
         ev(16'h012C, 16'h00C8, 16'h00C8, 16'h012C, 2'b00);
      end
      $display("Test filter done");
   endtask : t_filter

   task automatic t_comp();
      logic [7:0] d;
      wr(8'h46, 8'hA5);
      wr(8'h47, 8'h3C);
      wr(8'h48, 8'hDE);
      wr(8'h49, 8'h61);
      wr(8'h4A, 8'hFF);
      apply();
      for (int i = 6; i < 11; i++) begin
         rd(8'h40 + 8'(i), d);
         check(64'(d), (i < 10) ? 64'(shadow[i]) : 64'h0);
      end
      $display("Test compensation done");
   endtask : t_comp

   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_mode();
      t_shared();
      t_filter();
      t_comp();
      conclude();
   end

   // The tests need about 12000 cycles, so this limit only trips on a hang.
   initial begin
      repeat (30000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
endmodule : tb_top

`default_nettype wire
